// ===== hdl/wlt_tick_divider.sv
// divides the selected 32.768 kHz source ticks down to the timer tick
`timescale 1ns/1ps
`default_nettype none
`include "wlt_defs.svh"
module wlt_tick_divider
	import wlt_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic sys_clk,
	input wire logic reset,
	wlt_tick_if.div tif
);
	if (CNT_W != 16) begin : g_bad_width
		$error("wlt_tick_divider: CNT_W must be 16");
	end

	function automatic logic [15:0] termOf(input wlt_div_sel_t sel);
		case (sel)
			WLT_DIV_1: termOf = `WLT_TERM_DIV1;
			WLT_DIV_4: termOf = `WLT_TERM_DIV4;
			WLT_DIV_8: termOf = `WLT_TERM_DIV8;
			WLT_DIV_16: termOf = `WLT_TERM_DIV16;
			WLT_DIV_128: termOf = `WLT_TERM_DIV128;
			WLT_DIV_1024: termOf = `WLT_TERM_DIV1024;
			WLT_DIV_8192: termOf = `WLT_TERM_DIV8192;
			default: termOf = `WLT_TERM_DIV65536;
		endcase
	endfunction

	logic [CNT_W-1:0] divCnt_q;
	logic [CNT_W-1:0] divCnt_d;
	logic tick_q;
	wire [CNT_W-1:0] term = termOf(tif.divSel);
	// >= so that a smaller ratio chosen mid-count cannot strand the counter
	wire atTerm = divCnt_q >= term;

	assign divCnt_d = !tif.srcTick ? divCnt_q : (atTerm ? '0 : divCnt_q + 1'b1);
	assign tif.tick = tick_q;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			divCnt_q <= `WLT_RST_COUNT;
			tick_q <= 1'b0;
		end else begin
			divCnt_q <= divCnt_d;
			tick_q <= tif.srcTick && atTerm;
		end
	end

	chk_div_terminal: assert property (@(posedge sys_clk) disable iff (reset)
		(tif.srcTick && divCnt_q == term) |=> tif.tick)
		else $error("divider missed its terminal count");
	chk_div_quiet: assert property (@(posedge sys_clk) disable iff (reset)
		(!tif.srcTick || divCnt_q < term) |=> !tif.tick)
		else $error("divider ticked early");
endmodule
`default_nettype wire

// ===== hdl/wlt_wakeup_timer.sv
// wake-up timer unit: configuration bytes, reload counter, timeout flags
// How it works
// - the chosen 32.768 kHz source is divided by 1, 4, 8, 16, 128, 1024, 8192 or 65536 for codes 0 to 7.
// - a new reload high byte is staged and takes effect only when the low byte is written.
// - the reload value is 16 bits, upper byte in one write-only register and lower in the next.
// - the counter steps down once per divided tick and a zero reached while armed wakes the chip.
// - low configuration bit 4 picks the RC oscillator when one and the crystal when zero.
// - low configuration bit 6 turns the RC low-frequency oscillator on or off.
// - low configuration bit 5 turns the low-frequency crystal oscillator on or off.
// - low configuration bit 3 drives backupMemPowerKeep, which the sleep wipe clears at the first clock edge in sleep.
// - low configuration bit 0 arms the wake-up; unarmed, a timeout wakes nothing.
// - a one written to flag-clear bit 0 clears the latched timeout and cold-start flags.
// - flag-clear bit 1 enables RC oscillator calibration and resets to zero.
// - entering sleep wipes all configuration registers of this unit.
// - the live timeout bit is high exactly while the counter stands at zero.
// - the latched timeout bit holds each timeout until it is cleared.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "wlt_defs.svh"
module wlt_wakeup_timer
	import wlt_pkg::*;
#(
	parameter int ADDR_W = `WLT_ADDR_W,
	parameter int CNT_W = 16
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [7:0] regRdData,
	input wire logic rcOscTick,
	input wire logic xtalOscTick,
	input wire logic sleepState,
	output logic wakeupPulse,
	output logic rcOscEnable,
	output logic lfCrystalEnable,
	output logic tickSourceSelect,
	output logic backupMemPowerKeep,
	output logic rcOscCalEnable,
	output logic timeoutLiveFlag,
	output logic timeoutLatchedFlag,
	output logic coldStartFlag
);
	if (ADDR_W < 10 || CNT_W != 16) begin : g_bad_params
		$error("wlt_wakeup_timer: ADDR_W must be at least 10 and CNT_W 16");
	end

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	wlt_tick_if tif ();

	wlt_tick_divider #(
		.CNT_W(CNT_W)
	) u_divider (
		.sys_clk(sys_clk),
		.reset(reset),
		.tif(tif)
	);

	// configuration state
	logic [7:0] cfgHi_q;
	logic [7:0] cfgLo_q;
	logic [7:0] reloadHiPend_q;
	logic [CNT_W-1:0] reload_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic calEn_q;
	logic live_q;
	logic latched_q;
	logic cold_q;
	logic wake_q;
	logic [7:0] rdData_q;

	// address decode
	wire wrCfgHi = regWrStrobe && hit(regAddr, `WLT_OFS_CFG_HI);
	wire wrCfgLo = regWrStrobe && hit(regAddr, `WLT_OFS_CFG_LO);
	wire wrValHi = regWrStrobe && hit(regAddr, `WLT_OFS_VAL_HI);
	wire wrValLo = regWrStrobe && hit(regAddr, `WLT_OFS_VAL_LO);
	wire wrFlag = regWrStrobe && hit(regAddr, `WLT_OFS_FLAG);
	wire rdFlag = hit(regAddr, `WLT_OFS_FLAG);
	wire rdStatus = hit(regAddr, `WLT_OFS_STATUS);
	wire flagClr = wrFlag && regWrData[`WLT_FLAG_CLEAR];

	// a disabled oscillator delivers no ticks, whichever one is selected
	wire rcOn = cfgLo_q[`WLT_CFG_LO_RC_EN];
	wire xtalOn = cfgLo_q[`WLT_CFG_LO_XTAL_EN];
	wire useRc = cfgLo_q[`WLT_CFG_LO_SRCSEL];
	wire armed = cfgLo_q[`WLT_CFG_LO_ARM];
	wire srcTick = useRc ? (rcOscTick && rcOn) : (xtalOscTick && xtalOn);

	assign tif.srcTick = srcTick;
	assign tif.divSel = wlt_div_sel_t'(cfgHi_q[`WLT_CFG_HI_DIV_MSB:`WLT_CFG_HI_DIV_LSB]);

	wire divTick = tif.tick;
	wire [CNT_W-1:0] newReload = {reloadHiPend_q, regWrData};
	wire [CNT_W-1:0] cntStep = (cnt_q == '0) ? reload_q : cnt_q - 1'b1;
	wire timeoutEvt = divTick && !wrValLo && !sleepState && (cntStep == '0);

	// a low-byte write restarts the count from the freshly combined value
	assign cnt_d = sleepState ? `WLT_RST_COUNT :
		wrValLo ? newReload :
		divTick ? cntStep : cnt_q;

	wire [7:0] flagRead = {6'h00, calEn_q, 1'b0};
	wire [7:0] statusRead = {5'h00, cold_q, latched_q, live_q};
	wire [7:0] rdMux = !regRdStrobe ? 8'h00 :
		rdFlag ? flagRead :
		rdStatus ? statusRead : 8'h00;

	// configuration registers; sleep wipes them like the rest of modem configuration
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cfgHi_q <= `WLT_RST_BYTE;
			cfgLo_q <= `WLT_RST_BYTE;
			reloadHiPend_q <= `WLT_RST_BYTE;
			reload_q <= `WLT_RST_COUNT;
			calEn_q <= 1'b0;
		end else if (sleepState) begin
			cfgHi_q <= `WLT_RST_BYTE;
			cfgLo_q <= `WLT_RST_BYTE;
			reloadHiPend_q <= `WLT_RST_BYTE;
			reload_q <= `WLT_RST_COUNT;
			calEn_q <= 1'b0;
		end else begin
			if (wrCfgHi) begin
				cfgHi_q <= regWrData;
			end
			if (wrCfgLo) begin
				cfgLo_q <= regWrData;
			end
			if (wrValHi) begin
				reloadHiPend_q <= regWrData;
			end
			if (wrValLo) begin
				reload_q <= newReload;
			end
			if (wrFlag) begin
				calEn_q <= regWrData[`WLT_FLAG_CAL_EN];
			end
		end
	end

	// counter and flags; a timeout in the clearing cycle keeps its flag
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= `WLT_RST_COUNT;
			live_q <= 1'b1;
			latched_q <= 1'b0;
			cold_q <= `WLT_RST_COLD;
			wake_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			live_q <= (cnt_d == '0);
			latched_q <= timeoutEvt || (latched_q && !flagClr);
			cold_q <= cold_q && !flagClr;
			wake_q <= timeoutEvt && armed;
		end
	end

	// read data stand for the one cycle after the read strobe
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdData_q <= 8'h00;
		end else begin
			rdData_q <= rdMux;
		end
	end

	assign regRdData = rdData_q;
	assign wakeupPulse = wake_q;
	assign rcOscEnable = cfgLo_q[`WLT_CFG_LO_RC_EN];
	assign lfCrystalEnable = cfgLo_q[`WLT_CFG_LO_XTAL_EN];
	assign tickSourceSelect = cfgLo_q[`WLT_CFG_LO_SRCSEL];
	assign backupMemPowerKeep = cfgLo_q[`WLT_CFG_LO_BKMEM];
	assign rcOscCalEnable = calEn_q;
	assign timeoutLiveFlag = live_q;
	assign timeoutLatchedFlag = latched_q;
	assign coldStartFlag = cold_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence lowWrite;
		wrValLo && !sleepState;
	endsequence

	chk_reload_apply: assert property (lowWrite |=>
		reload_q == {$past(reloadHiPend_q), $past(regWrData)} && cnt_q == reload_q)
		else $error("low byte write did not apply the staged reload");
	chk_high_staged: assert property ((wrValHi && !sleepState) |=>
		reload_q == $past(reload_q) && reloadHiPend_q == $past(regWrData))
		else $error("high byte write changed the reload early");
	chk_count_down: assert property ((divTick && cnt_q != '0 && !wrValLo && !sleepState)
		|=> cnt_q == $past(cnt_q) - 1'b1)
		else $error("counter did not step down on a tick");
	chk_zero_reload: assert property ((divTick && cnt_q == '0 && !wrValLo && !sleepState)
		|=> cnt_q == $past(reload_q))
		else $error("counter did not reload after zero");
	chk_wake_armed: assert property ((timeoutEvt && armed) |=> wakeupPulse ##1 !wakeupPulse)
		else $error("armed timeout gave no single wake pulse");
	chk_wake_unarmed: assert property (!$past(armed) |-> !wakeupPulse)
		else $error("wake pulse while not armed");
	chk_live_zero: assert property ((cnt_q == '0) == timeoutLiveFlag)
		else $error("live timeout bit disagrees with the counter");
	chk_latch_hold: assert property ((timeoutLatchedFlag && !flagClr) |=> timeoutLatchedFlag)
		else $error("latched timeout dropped without a clear");
	chk_flag_clear: assert property ((flagClr && !timeoutEvt) |=>
		!timeoutLatchedFlag && !coldStartFlag)
		else $error("flag clear left a flag set");
	chk_sleep_wipe: assert property (sleepState |=>
		cfgLo_q == 8'h00 && cfgHi_q == 8'h00 && reload_q == '0 && !rcOscCalEnable)
		else $error("sleep did not wipe configuration");
	chk_src_gate: assert property ((tickSourceSelect && !rcOscEnable) |-> !srcTick)
		else $error("disabled RC source still ticked");
	chk_cal_enable: assert property ((wrFlag && !sleepState) |=>
		rcOscCalEnable == $past(regWrData[`WLT_FLAG_CAL_EN]))
		else $error("calibration enable not taken");

	cov_wake: cover property (wakeupPulse);
	cov_clear_race: cover property (flagClr && timeoutEvt);
	cov_reload_cycle: cover property (lowWrite ##[1:300] timeoutEvt);
	cov_sleep: cover property (sleepState ##1 !sleepState);
endmodule
`default_nettype wire

// ===== inc/wlt_defs.svh
// register offsets, field positions, reset values and divider counts of the wake-up timer
`ifndef WLT_DEFS_SVH
`define WLT_DEFS_SVH

`define WLT_ADDR_W 10
`define WLT_OFS_CFG_HI 10'h30C
`define WLT_OFS_CFG_LO 10'h30D
`define WLT_OFS_VAL_HI 10'h30E
`define WLT_OFS_VAL_LO 10'h30F
`define WLT_OFS_FLAG 10'h310
`define WLT_OFS_STATUS 10'h311

`define WLT_RST_BYTE 8'h00
`define WLT_RST_COUNT 16'h0000
`define WLT_RST_COLD 1'b1

`define WLT_CFG_HI_DIV_MSB 2
`define WLT_CFG_HI_DIV_LSB 0
`define WLT_CFG_LO_ARM 0
`define WLT_CFG_LO_BKMEM 3
`define WLT_CFG_LO_SRCSEL 4
`define WLT_CFG_LO_XTAL_EN 5
`define WLT_CFG_LO_RC_EN 6
`define WLT_FLAG_CLEAR 0
`define WLT_FLAG_CAL_EN 1
`define WLT_STAT_LIVE 0
`define WLT_STAT_LATCHED 1
`define WLT_STAT_COLD 2

// last value of the source-tick counter for each divide ratio
`define WLT_TERM_DIV1 16'h0000
`define WLT_TERM_DIV4 16'h0003
`define WLT_TERM_DIV8 16'h0007
`define WLT_TERM_DIV16 16'h000F
`define WLT_TERM_DIV128 16'h007F
`define WLT_TERM_DIV1024 16'h03FF
`define WLT_TERM_DIV8192 16'h1FFF
`define WLT_TERM_DIV65536 16'hFFFF

`endif

// ===== inc/wlt_pkg.sv
// types shared by the wake-up timer modules
package wlt_pkg;
	typedef enum logic [2:0] {
		WLT_DIV_1 = 3'b000,
		WLT_DIV_4 = 3'b001,
		WLT_DIV_8 = 3'b010,
		WLT_DIV_16 = 3'b011,
		WLT_DIV_128 = 3'b100,
		WLT_DIV_1024 = 3'b101,
		WLT_DIV_8192 = 3'b110,
		WLT_DIV_65536 = 3'b111
	} wlt_div_sel_t;
endpackage

// ===== inc/wlt_tick_if.sv
// carrier between the timer core and its tick divider
`timescale 1ns/1ps
`default_nettype none
interface wlt_tick_if;
	import wlt_pkg::*;
	logic srcTick;
	wlt_div_sel_t divSel;
	logic tick;
	modport core (output srcTick, output divSel, input tick);
	modport div (input srcTick, input divSel, output tick);
endinterface
`default_nettype wire

// ===== sim/testbench.sv
// register-level bench for the wake-up timer unit
`timescale 1ns/1ps
`default_nettype none
`include "wlt_defs.svh"
module testbench;
	import wlt_pkg::*;
	logic clk, rst, wrStb, rdStb, rcTick, xtTick, sleep, wakeup;
	logic rcEn, xtEn, srcSel, bkKeep, calEn, live, latched, cold;
	logic [9:0] addr;
	logic [7:0] wrData;
	logic [7:0] rdData;
	int miscompares, samplesChecked, wakeCount, w;
	wire logic [7:0] outs;
	assign outs = {rcEn, xtEn, srcSel, bkKeep, calEn, live, latched, cold};

	wlt_wakeup_timer wlt_wakeup_timer_inst (.sys_clk(clk), .reset(rst), .regAddr(addr),
		.regWrData(wrData), .regWrStrobe(wrStb), .regRdStrobe(rdStb), .regRdData(rdData),
		.rcOscTick(rcTick), .xtalOscTick(xtTick), .sleepState(sleep), .wakeupPulse(wakeup),
		.rcOscEnable(rcEn), .lfCrystalEnable(xtEn), .tickSourceSelect(srcSel),
		.backupMemPowerKeep(bkKeep), .rcOscCalEnable(calEn), .timeoutLiveFlag(live),
		.timeoutLatchedFlag(latched), .coldStartFlag(cold));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// wake pulses last one cycle, so they are tallied rather than polled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) wakeCount <= 0;
		else if (wakeup) wakeCount <= wakeCount + 1;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		wrStb <= 1'b1;
		addr <= a;
		wrData <= d;
		@(posedge clk);
		wrStb <= 1'b0;
		#1;
	endtask

	task rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clk);
		rdStb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 chk(rdData, e);
	endtask

	// one source tick, then enough idle cycles for divider, counter and wake pulse to settle
	task pulse(input logic useRc);
		@(posedge clk);
		if (useRc) rcTick <= 1'b1;
		else xtTick <= 1'b1;
		@(posedge clk);
		rcTick <= 1'b0;
		xtTick <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// reload 0 makes every divided tick a timeout, so the wake spacing is the divide ratio
	task measure(input logic [2:0] code, input logic useRc, input int div);
		int n;
		wr(`WLT_OFS_CFG_HI, {5'h00, code});
		wr(`WLT_OFS_CFG_LO, useRc ? 8'h51 : 8'h21);
		wr(`WLT_OFS_VAL_HI, 8'h00);
		wr(`WLT_OFS_VAL_LO, 8'h00);
		for (int p = 0; p < 2; p++) begin
			n = 0;
			w = wakeCount;
			while (wakeCount == w && n < 70000) begin
				pulse(useRc);
				n++;
			end
		end
		chk(n, div);
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		#4000000;
		miscompares++;
		report_and_stop();
	end

	initial begin
		{wrStb, rdStb, rcTick, xtTick, sleep} = 5'h00;
		addr = 10'h000;
		wrData = 8'h00;
		miscompares = 0;
		samplesChecked = 0;
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1 chk(outs, 8'h05);
		rd(`WLT_OFS_STATUS, 8'h05);
		rd(`WLT_OFS_CFG_HI, 8'h00);
		rd(`WLT_OFS_VAL_LO, 8'h00);
		rd(10'h000, 8'h00);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			wr(`WLT_OFS_CFG_HI, 8'h00);
			wr(`WLT_OFS_CFG_LO, 8'h08 << k);
			chk(outs[7:4], 4'h1 << k);
		end
		wr(`WLT_OFS_FLAG, 8'h02);
		chk(outs, 8'h8D);
		rd(`WLT_OFS_FLAG, 8'h02);
		wr(`WLT_OFS_FLAG, 8'h03);
		rd(`WLT_OFS_STATUS, 8'h01);
		wr(`WLT_OFS_STATUS, 8'hFF);
		rd(`WLT_OFS_STATUS, 8'h01);
		$display("test config done");
		wr(`WLT_OFS_CFG_HI, 8'h00);
		wr(`WLT_OFS_CFG_LO, 8'h51);
		wr(`WLT_OFS_VAL_HI, 8'h00);
		wr(`WLT_OFS_VAL_LO, 8'h02);
		rd(`WLT_OFS_STATUS, 8'h00);
		w = wakeCount;
		pulse(1'b1);
		chk(live, 1'b0);
		pulse(1'b1);
		chk(wakeCount, w + 1);
		rd(`WLT_OFS_STATUS, 8'h03);
		pulse(1'b1);
		rd(`WLT_OFS_STATUS, 8'h02);
		wr(`WLT_OFS_VAL_HI, 8'h01);
		pulse(1'b1);
		pulse(1'b1);
		chk(live, 1'b1);
		wr(`WLT_OFS_VAL_LO, 8'h00);
		repeat (255) pulse(1'b1);
		chk(live, 1'b0);
		pulse(1'b1);
		chk(live, 1'b1);
		wr(`WLT_OFS_FLAG, 8'h01);
		rd(`WLT_OFS_STATUS, 8'h01);
		$display("test count done");
		wr(`WLT_OFS_CFG_HI, 8'h00);
		wr(`WLT_OFS_CFG_LO, 8'h50);
		wr(`WLT_OFS_VAL_HI, 8'h00);
		wr(`WLT_OFS_VAL_LO, 8'h01);
		w = wakeCount;
		pulse(1'b1);
		chk(outs[2:1], 2'h3);
		chk(wakeCount, w);
		$display("test unarmed done");
		for (int c = 0; c < 6; c++) measure(c[2:0], 1'b1, c < 4 ? (c == 0 ? 1 : 2 << c) : 16 << (3 * (c - 3)));
		measure(3'h2, 1'b0, 8);
		$display("test divider done");
		wr(`WLT_OFS_CFG_HI, 8'h00);
		wr(`WLT_OFS_CFG_LO, 8'h79);
		wr(`WLT_OFS_FLAG, 8'h02);
		@(posedge clk);
		sleep <= 1'b1;
		wr(`WLT_OFS_CFG_LO, 8'h79);
		sleep <= 1'b0;
		@(posedge clk);
		#1 chk(outs, 8'h06);
		$display("test sleep done");
		report_and_stop();
	end
endmodule
`default_nettype wire
